// file: hw/arith_datapath.sv
// Transfer/arithmetic datapath with register file, flags and scratch memory.
// Assumes an AHB-Lite master issuing single word transfers; one command per write.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module arith_datapath #(
  parameter int MEM_BYTES = dp_pkg::MEM_BYTES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  localparam int AW = $clog2(MEM_BYTES);

  if (MEM_BYTES < 8 || MEM_BYTES > 64 || (MEM_BYTES & (MEM_BYTES - 1)) != 0) begin : g_chk
    $error("MEM_BYTES must be a power of two from 8 to 64");
  end

  // ==================================================
  // State
  logic [31:0] regs_q [dp_pkg::NUM_REGS];
  logic [7:0] mem_q [MEM_BYTES];
  dp_pkg::flags_type flags_q;
  logic [31:0] imm_q;
  logic illegal_q;
  logic [7:0] count_q;
  logic ap_valid_q, ap_write_q, rd_done_q;
  logic [7:0] ap_addr_q;
  logic [31:0] hrdata_q, rd_mux;

  // ==================================================
  // Helpers
  // Byte view picks high/low byte of the low half; word view picks upper/lower half
  function automatic logic [31:0] reg_rd(input logic [3:0] sel, input dp_pkg::size_type sz);
    logic [31:0] r;
    r = regs_q[sel[2:0]];
    case (sz)
      dp_pkg::size_byte: return sel[3] ? 32'(r[15:8]) : 32'(r[7:0]);
      dp_pkg::size_word: return sel[3] ? 32'(r[31:16]) : 32'(r[15:0]);
      default: return r;
    endcase
  endfunction

  function automatic logic [31:0] reg_merge(input logic [31:0] r, input logic [3:0] sel,
                                            input dp_pkg::size_type sz, input logic [31:0] v);
    logic [31:0] t;
    t = r;
    case (sz)
      dp_pkg::size_byte: if (sel[3]) t[15:8] = v[7:0]; else t[7:0] = v[7:0];
      dp_pkg::size_word: if (sel[3]) t[31:16] = v[15:0]; else t[15:0] = v[15:0];
      default: t = v;
    endcase
    return t;
  endfunction

  // Big-endian: lowest address holds the most significant byte
  function automatic logic [31:0] mem_rd(input logic [AW-1:0] a, input dp_pkg::size_type sz);
    logic [31:0] w;
    w = {mem_q[a], mem_q[AW'(a + 1)], mem_q[AW'(a + 2)], mem_q[AW'(a + 3)]};
    case (sz)
      dp_pkg::size_byte: return 32'(w[31:24]);
      dp_pkg::size_word: return 32'(w[31:16]);
      default: return w;
    endcase
  endfunction

  function automatic dp_pkg::flags_type nz_flags(input dp_pkg::flags_type f,
                                                 input logic [31:0] v, input logic [4:0] s);
    logic [31:0] t;
    dp_pkg::flags_type o;
    t = v << s;
    o = f;
    o.n = t[31];
    o.z = (t == 32'h0000_0000);
    o.v = 1'b0;
    return o;
  endfunction

  // ==================================================
  // AHB-Lite slave: writes take no wait, reads one wait state
  // The read wait lets a read see a write that finished the cycle before.
  wire addr_take = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[1:0] == 2'h0;
  wire rd_stall = ap_valid_q && !ap_write_q && !rd_done_q;
  wire wr_fire = ap_valid_q && ap_write_q;
  wire [7:0] reg_rel = ap_addr_q - dp_pkg::OFF_REGS;
  wire [7:0] mem_rel = ap_addr_q - dp_pkg::OFF_MEM;
  wire in_regs = reg_rel < dp_pkg::REGS_SPAN;
  wire in_mem = mem_rel < 8'(MEM_BYTES);
  wire hit_cmd = wr_fire && ap_addr_q == dp_pkg::OFF_CMD;
  assign hreadyout = !rd_stall;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
      rd_done_q <= 1'b0;
    end else begin
      if (hready) begin
        ap_valid_q <= addr_take;
        ap_write_q <= hwrite;
        ap_addr_q <= haddr[7:0];
      end
      rd_done_q <= rd_stall;
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ap_addr_q == dp_pkg::OFF_IMM) rd_mux = imm_q;
    else if (ap_addr_q == dp_pkg::OFF_FLAGS) rd_mux = 32'(flags_q);
    else if (ap_addr_q == dp_pkg::OFF_STATUS) begin
      rd_mux[dp_pkg::STAT_ILLEGAL_BIT] = illegal_q;
      rd_mux[dp_pkg::STAT_COUNT_LSB +: 8] = count_q;
    end
    else if (in_regs) rd_mux = regs_q[reg_rel[4:2]];
    else if (in_mem) rd_mux = mem_rd(mem_rel[AW-1:0], dp_pkg::size_long);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_q <= 32'h0000_0000;
    else if (rd_stall) hrdata_q <= rd_mux;
  end

  // ==================================================
  // Command decode and operands
  dp_pkg::cmd_type cmd;
  logic [31:0] imm_mask, imm_v, disp, step_v, nb32, a, b, ar_b;
  logic [4:0] sh;
  dp_pkg::size_type wide_sz;
  int nbytes;
  assign cmd = dp_pkg::cmd_type'(hwdata);
  wire is_mul = cmd.op == dp_pkg::unsigned_multiply_op || cmd.op == dp_pkg::signed_multiply_op;
  wire is_incdec = cmd.op == dp_pkg::op_inc || cmd.op == dp_pkg::op_dec;
  wire is_carry = cmd.op == dp_pkg::add_with_carry_op || cmd.op == dp_pkg::sub_with_borrow_op;
  wire size_ok = cmd.size inside {dp_pkg::size_byte, dp_pkg::size_word, dp_pkg::size_long};
  wire is_byte = cmd.size == dp_pkg::size_byte;
  wire is_long = cmd.size == dp_pkg::size_long;
  assign wide_sz = is_byte ? dp_pkg::size_word : dp_pkg::size_long;
  // Operand fetch sits in a process so a register update wakes it;
  // a continuous assignment would only wake on the function's arguments
  always_comb begin
    a = reg_rd(cmd.dst, is_mul ? wide_sz : cmd.size);
    b = cmd.use_imm ? imm_v : reg_rd(cmd.src, cmd.size);
  end
  assign nbytes = int'(nb32);

  // Field length masks and width-dependent shift
  always_comb begin
    case (cmd.len)
      2'h0: imm_mask = 32'h0000_0007;
      2'h1: imm_mask = 32'h0000_00FF;
      2'h2: imm_mask = 32'h0000_FFFF;
      default: imm_mask = 32'h00FF_FFFF;
    endcase
    case (cmd.size)
      dp_pkg::size_byte: begin
        sh = 5'h18;
        nb32 = 32'h0000_0001;
      end
      dp_pkg::size_word: begin
        sh = 5'h10;
        nb32 = 32'h0000_0002;
      end
      default: begin
        sh = 5'h00;
        nb32 = 32'h0000_0004;
      end
    endcase
    case (cmd.step)
      2'h0: step_v = 32'h0000_0001;
      2'h1: step_v = 32'h0000_0002;
      default: step_v = 32'h0000_0004;
    endcase
  end

  // Immediates are zero-extended, displacements sign-extended from the field
  wire disp_neg = |(imm_q & (imm_mask ^ (imm_mask >> 1)));
  assign imm_v = imm_q & imm_mask;
  assign disp = disp_neg ? (imm_v | ~imm_mask) : imm_v;

  // ==================================================
  // Shared adder: operands moved to the top so N, V and C come from bit 31/32, H from bit 28
  logic [31:0] as, bs, cs, ar_res;
  logic [32:0] sum;
  logic ar_v, ar_h;
  wire ar_sub = cmd.op == dp_pkg::op_sub || cmd.op == dp_pkg::sub_with_borrow_op ||
                cmd.op == dp_pkg::op_dec;
  assign ar_b = is_incdec ? step_v : b;
  assign as = a << sh;
  assign bs = ar_b << sh;
  assign cs = 32'(is_carry && flags_q.c) << sh;
  assign sum = ar_sub ? {1'b0, as} - {1'b0, bs} - {1'b0, cs} : {1'b0, as} + {1'b0, bs} + {1'b0, cs};
  assign ar_res = sum[31:0] >> sh;
  assign ar_v = (ar_sub ? as[31] != bs[31] : as[31] == bs[31]) && sum[31] != as[31];
  assign ar_h = sum[28] ^ as[28] ^ bs[28];

  // Decimal fix on the low byte, driven by half-carry and carry
  logic [7:0] dec_corr, dec_res;
  logic dec_c;
  wire is_daa = cmd.op == dp_pkg::decimal_fix_after_sum;
  always_comb begin
    dec_corr = 8'h00;
    dec_c = flags_q.c;
    if (flags_q.h || (is_daa && a[3:0] > 4'h9)) dec_corr[3:0] = 4'h6;
    if (flags_q.c || (is_daa && a[7:0] > 8'h99)) begin
      dec_corr[7:4] = 4'h6;
      dec_c = 1'b1;
    end
    dec_res = is_daa ? 8'(a[7:0] + dec_corr) : 8'(a[7:0] - dec_corr);
  end

  // Multipliers: byte operands widened to 16 bits before the product
  logic [15:0] ma_u, mb_u, ma_s, mb_s;
  logic [31:0] prod_u, prod_s;
  assign ma_u = is_byte ? 16'(a[7:0]) : a[15:0];
  assign mb_u = is_byte ? 16'(b[7:0]) : b[15:0];
  assign ma_s = is_byte ? {{8{a[7]}}, a[7:0]} : a[15:0];
  assign mb_s = is_byte ? {{8{b[7]}}, b[7:0]} : b[15:0];
  // Operands widened to 32 bits; after sign extension the low word is the signed product
  assign prod_u = 32'(ma_u) * 32'(mb_u);
  assign prod_s = {{16{ma_s[15]}}, ma_s} * {{16{mb_s[15]}}, mb_s};

  // ==================================================
  // Operation select
  logic legal, wr_en, sp_en, mw_en;
  logic [3:0] wr_sel;
  dp_pkg::size_type wr_sz;
  logic [31:0] wr_val, sp_val, mw_addr, mw_val;
  dp_pkg::flags_type fl_d, fl_ar;
  wire [31:0] sp = regs_q[dp_pkg::SP_INDEX];
  wire ok_exec = hit_cmd && legal;

  always_comb begin
    fl_ar = flags_q;
    fl_ar.n = sum[31];
    fl_ar.z = sum[31:0] == 32'h0000_0000;
    fl_ar.v = ar_v;
    fl_ar.c = sum[32];
    fl_ar.h = ar_h;
  end

  always_comb begin
    legal = size_ok;
    wr_en = 1'b0;
    wr_sel = cmd.dst;
    wr_sz = cmd.size;
    wr_val = ar_res;
    sp_en = 1'b0;
    sp_val = sp;
    mw_en = 1'b0;
    mw_addr = sp - nb32;
    mw_val = reg_rd(cmd.src, cmd.size);
    fl_d = flags_q;
    case (cmd.op)
      dp_pkg::op_move_reg, dp_pkg::op_move_imm, dp_pkg::op_move_load: begin
        wr_en = 1'b1;
        wr_val = cmd.op == dp_pkg::op_move_reg ? reg_rd(cmd.src, cmd.size) :
                 cmd.op == dp_pkg::op_move_imm ? imm_v :
                 mem_rd(AW'(reg_rd(cmd.src, dp_pkg::size_long) + disp), cmd.size);
        fl_d = nz_flags(flags_q, wr_val, sh);
      end
      dp_pkg::op_move_store: begin
        mw_en = 1'b1;
        mw_addr = reg_rd(cmd.dst, dp_pkg::size_long) + disp;
        fl_d = nz_flags(flags_q, mw_val, sh);
      end
      dp_pkg::op_stack_read: begin
        legal = size_ok && !is_byte;
        wr_en = 1'b1;
        wr_val = mem_rd(sp[AW-1:0], cmd.size);
        sp_en = 1'b1;
        sp_val = sp + nb32;
        fl_d = nz_flags(flags_q, wr_val, sh);
      end
      dp_pkg::op_stack_write: begin
        legal = size_ok && !is_byte;
        sp_en = 1'b1;
        sp_val = sp - nb32;
        mw_en = 1'b1;
        fl_d = nz_flags(flags_q, mw_val, sh);
      end
      dp_pkg::op_add, dp_pkg::op_sub: begin
        legal = size_ok && !(cmd.op == dp_pkg::op_sub && cmd.use_imm && is_byte);
        wr_en = 1'b1;
        fl_d = fl_ar;
      end
      dp_pkg::add_with_carry_op, dp_pkg::sub_with_borrow_op: begin
        legal = is_byte;
        wr_en = 1'b1;
        fl_d = fl_ar;
        fl_d.z = flags_q.z && fl_ar.z; // Zero only sticks across a multi-byte chain
      end
      dp_pkg::op_inc, dp_pkg::op_dec: begin
        legal = size_ok && (is_byte ? cmd.step == 2'h0 : cmd.step <= 2'h1);
        wr_en = 1'b1;
        fl_d = fl_ar;
        fl_d.c = flags_q.c;
        fl_d.h = flags_q.h;
      end
      dp_pkg::address_step_up_op, dp_pkg::address_step_down_op: begin
        legal = is_long && cmd.step != 2'h3;
        wr_en = 1'b1;
        wr_val = cmd.op == dp_pkg::address_step_up_op ? a + step_v : a - step_v;
      end
      dp_pkg::decimal_fix_after_sum, dp_pkg::decimal_fix_after_diff: begin
        legal = is_byte;
        wr_en = 1'b1;
        wr_val = 32'(dec_res);
        fl_d = nz_flags(flags_q, wr_val, sh);
        fl_d.v = flags_q.v;
        fl_d.c = dec_c;
      end
      dp_pkg::unsigned_multiply_op, dp_pkg::signed_multiply_op: begin
        legal = size_ok && !is_long;
        wr_en = 1'b1;
        wr_sz = wide_sz;
        wr_val = cmd.op == dp_pkg::signed_multiply_op ? prod_s : prod_u;
        if (cmd.op == dp_pkg::signed_multiply_op) begin
          fl_d = nz_flags(flags_q, wr_val, is_byte ? 5'h10 : 5'h00);
          fl_d.v = flags_q.v;
        end
      end
      dp_pkg::peripheral_read_move, dp_pkg::peripheral_write_move: legal = 1'b0;
      default: legal = 1'b0;
    endcase
  end

  // ==================================================
  // Register file: bus write wins; result written after stack pointer so a
  // pop into the stack pointer keeps the loaded data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < dp_pkg::NUM_REGS; i++) regs_q[i] <= 32'h0000_0000;
    end else if (wr_fire && in_regs) begin
      regs_q[reg_rel[4:2]] <= hwdata;
    end else if (ok_exec) begin
      if (sp_en) regs_q[dp_pkg::SP_INDEX] <= sp_val;
      if (wr_en) regs_q[wr_sel[2:0]] <= reg_merge(regs_q[wr_sel[2:0]], wr_sel, wr_sz, wr_val);
    end
  end

  // Scratch memory, not reset; addresses wrap inside its size
  always_ff @(posedge hclk) begin
    if (wr_fire && in_mem) begin
      for (int k = 0; k < 4; k++) mem_q[AW'(mem_rel[AW-1:0] + k)] <= hwdata[31 - 8 * k -: 8];
    end else if (ok_exec && mw_en) begin
      for (int k = 0; k < 4; k++) begin
        if (k < nbytes) mem_q[AW'(mw_addr[AW-1:0] + k)] <= mw_val[8 * (nbytes - 1 - k) +: 8];
      end
    end
  end

  // Flags and immediate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= dp_pkg::flags_type'(dp_pkg::FLAGS_RST);
      imm_q <= dp_pkg::IMM_RST;
    end else begin
      if (wr_fire && ap_addr_q == dp_pkg::OFF_IMM) imm_q <= hwdata;
      if (wr_fire && ap_addr_q == dp_pkg::OFF_FLAGS) flags_q <= dp_pkg::flags_type'(hwdata[7:0]);
      else if (ok_exec) flags_q <= fl_d;
    end
  end

  // Refusal flag is sticky; a new refusal beats a clear in the same cycle
  wire clr_illegal = wr_fire && ap_addr_q == dp_pkg::OFF_STATUS && hwdata[0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      illegal_q <= 1'b0;
      count_q <= 8'h00;
    end else begin
      if (hit_cmd && !legal) illegal_q <= 1'b1;
      else if (clr_illegal) illegal_q <= 1'b0;
      if (ok_exec) count_q <= count_q + 8'h01;
    end
  end

  // ==================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_move_copy: assert property (ok_exec && cmd.op == dp_pkg::op_move_reg
    |=> reg_rd($past(cmd.dst), $past(cmd.size)) == $past(b)) else $error("move lost data");
  chk_pop_sp: assert property (ok_exec && cmd.op == dp_pkg::op_stack_read
    && cmd.dst[2:0] != 3'h7 |=> regs_q[dp_pkg::SP_INDEX] == $past(sp) + $past(nb32))
    else $error("pop did not advance stack pointer");
  chk_push_sp: assert property (ok_exec && cmd.op == dp_pkg::op_stack_write
    |=> regs_q[dp_pkg::SP_INDEX] == $past(sp) - $past(nb32)
    && mem_rd(regs_q[dp_pkg::SP_INDEX][AW-1:0], $past(cmd.size)) == $past(mw_val))
    else $error("push wrong");
  chk_sub_refuse: assert property (hit_cmd && cmd.op == dp_pkg::op_sub
    && cmd.use_imm && is_byte |-> !ok_exec ##1 illegal_q) else $error("byte immediate subtract ran");
  chk_carry_sum: assert property (ok_exec && cmd.op == dp_pkg::add_with_carry_op
    |=> reg_rd($past(cmd.dst), dp_pkg::size_byte)
    == 32'($past(8'(a[7:0] + b[7:0] + 8'(flags_q.c))))) else $error("carry add wrong");
  chk_inc_byte: assert property (hit_cmd && is_incdec && is_byte && cmd.step != 2'h0
    |=> illegal_q && $stable(count_q)) else $error("byte step of 2 accepted");
  chk_step_long: assert property (hit_cmd && !is_long
    && (cmd.op == dp_pkg::address_step_up_op || cmd.op == dp_pkg::address_step_down_op)
    |-> !legal) else $error("address step accepted short size");
  chk_mul_unsigned: assert property (ok_exec && cmd.op == dp_pkg::unsigned_multiply_op
    && is_byte |=> reg_rd($past(cmd.dst), dp_pkg::size_word) == 32'($past(a[7:0]) * $past(b[7:0])))
    else $error("unsigned multiply wrong");
  chk_add_flags: assert property (ok_exec && (cmd.op == dp_pkg::op_add || cmd.op == dp_pkg::op_sub)
    |=> flags_q.z == (reg_rd($past(cmd.dst), $past(cmd.size)) == 32'h0000_0000)
    && flags_q.c == $past(sum[32]))
    else $error("arith flags wrong");
  chk_periph_off: assert property (hit_cmd && (cmd.op == dp_pkg::peripheral_read_move
    || cmd.op == dp_pkg::peripheral_write_move) |-> !ok_exec ##1 illegal_q)
    else $error("peripheral move executed");
endmodule // arith_datapath

// file: hw/dp_pkg.sv
// Constants and types shared by the transfer/arithmetic datapath.
// Assumes one AHB-Lite slave port decoding the low eight address bits.
package dp_pkg;
  // ==================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_IMM = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_REGS = 8'h40;
  localparam logic [7:0] REGS_SPAN = 8'h20;
  localparam logic [7:0] OFF_MEM = 8'h80;
  // ==================================================
  // Sizes and reset values
  localparam int NUM_REGS = 8;
  localparam int SP_INDEX = 7;
  localparam int MEM_BYTES_DEF = 64;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [31:0] IMM_RST = 32'h0000_0000;
  localparam int STAT_ILLEGAL_BIT = 0;
  localparam int STAT_COUNT_LSB = 8;
  // ==================================================
  // Operations, sizes, command word, flags
  typedef enum logic [4:0] {
    op_nop, op_move_reg, op_move_imm, op_move_load, op_move_store,
    op_stack_read, op_stack_write, op_add, op_sub, add_with_carry_op,
    sub_with_borrow_op, op_inc, op_dec, address_step_up_op, address_step_down_op,
    decimal_fix_after_sum, decimal_fix_after_diff, unsigned_multiply_op,
    signed_multiply_op, peripheral_read_move, peripheral_write_move
  } op_type;
  typedef enum logic [1:0] {size_byte, size_word, size_long} size_type;
  typedef struct packed {
    logic [10:0] spare;
    logic [1:0] len;
    logic [1:0] step;
    logic use_imm;
    logic [3:0] src;
    logic [3:0] dst;
    logic pad;
    size_type size;
    op_type op;
  } cmd_type;
  typedef struct packed {
    logic [1:0] spare;
    logic h;
    logic u;
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_type;
endpackage

// file: verification/bus_master_model.sv
// Bus master model standing for the decoder side: single word AHB-Lite transfers.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/1ps
module bus_master_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ==================================================
  // Idle bus from time zero
  initial begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  end
  // ==================================================
  // One transfer; each phase held until hready is seen high at a falling edge
  // hready is looked at mid-cycle: at the rising edge itself it races the slave's flops
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    logic seen;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    seen = 1'b0;
    while (!seen) begin
      @(negedge hclk);
      seen = (hready === 1'b1);
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= {24'hFF_FFFF, ~a}; // Stale address would hide decode slips
    hwdata <= wd;
    seen = 1'b0;
    while (!seen) begin
      @(negedge hclk);
      seen = (hready === 1'b1);
      rd = hrdata;
      @(posedge hclk);
    end
  endtask
endmodule // bus_master_model

// file: verification/tb_top.sv
// Self-checking bench for the datapath: command table, stack, memory, reset.
// Assumes bus_master_model drives the bus; ER1 is the destination, ER2 the source.
`timescale 1ns/1ps
module tb_top;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] rd;
  int bad_count;
  int tests_run;
  typedef struct {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] imm;
    logic [31:0] cmd;
    logic [7:0] fin;
    logic [31:0] exp;
    logic [31:0] fexp;
  } row_type;
  row_type rows[$];
  // ==================================================
  // Design, bus master, clock
  arith_datapath #(.MEM_BYTES(64)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  bus_master_model m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ==================================================
  // Helpers: command word, bus access, comparison, verdict
  function automatic logic [31:0] c(input logic [4:0] op, input logic [1:0] sz,
    input logic [3:0] d, input logic [3:0] s, input logic ui, input logic [1:0] st,
    input logic [1:0] ln);
    return {11'h000, ln, st, ui, s, d, 1'b0, sz, op};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rd);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    m.xfer(1'b0, a, 32'h0, rd);
    cmp(rd & msk, exp);
  endtask
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    end_of_test;
  end
  // ==================================================
  // Main sequence: table rows first, then hand-written cases
  initial begin
    hresetn = 1'b0;
    rows = '{
      '{32'h7FFF_FFFF, 32'h1, 32'h0, c(7, 2, 1, 2, 0, 0, 0), 8'h0, 32'h8000_0000, 32'hA},
      '{32'h1234_56FF, 32'h1, 32'h0, c(7, 0, 1, 2, 0, 0, 0), 8'h0, 32'h1234_5600, 32'h5},
      '{32'h5, 32'h0, 32'h6, c(8, 1, 1, 2, 1, 0, 1), 8'h0, 32'hFFFF, 32'h9},
      '{32'h11, 32'h0, 32'h1, c(8, 0, 1, 2, 1, 0, 1), 8'h3, 32'h11, 32'h3},
      '{32'h10, 32'h20, 32'h0, c(9, 0, 1, 2, 0, 0, 0), 8'h1, 32'h31, 32'h0},
      '{32'h10, 32'hF, 32'h0, c(10, 0, 1, 2, 0, 0, 0), 8'h5, 32'h0, 32'h4},
      '{32'h1_FFFF, 32'h0, 32'h0, c(11, 1, 1, 2, 0, 1, 0), 8'h1, 32'h1_0001, 32'h1},
      '{32'h7, 32'h0, 32'h0, c(11, 0, 1, 2, 0, 1, 0), 8'h0, 32'h7, 32'h0},
      '{32'h100, 32'h0, 32'h0, c(12, 0, 1, 2, 0, 0, 0), 8'h0, 32'h1FF, 32'h8},
      '{32'h8000_0000, 32'h0, 32'h0, c(12, 2, 1, 2, 0, 0, 0), 8'h0, 32'h7FFF_FFFF, 32'h2},
      '{32'hFFFF_FFFE, 32'h0, 32'h0, c(13, 2, 1, 2, 0, 2, 0), 8'hF, 32'h2, 32'hF},
      '{32'h1, 32'h0, 32'h0, c(14, 2, 1, 2, 0, 1, 0), 8'h0, 32'hFFFF_FFFF, 32'h0},
      '{32'h9, 32'h0, 32'h0, c(14, 1, 1, 2, 0, 0, 0), 8'h0, 32'h9, 32'h0},
      '{32'h1A, 32'h0, 32'h0, c(15, 0, 1, 2, 0, 0, 0), 8'h0, 32'h20, 32'h0},
      '{32'hA5, 32'h0, 32'h0, c(16, 0, 1, 2, 0, 0, 0), 8'h1, 32'h45, 32'h1},
      '{32'hFF, 32'h2, 32'h0, c(17, 0, 1, 2, 0, 0, 0), 8'h0, 32'h1FE, 32'h0},
      '{32'hFFFF, 32'h3, 32'h0, c(18, 1, 1, 2, 0, 0, 0), 8'h0, 32'hFFFF_FFFD, 32'h8},
      '{32'h0, 32'h0, 32'h00AB_CDEF, c(2, 2, 1, 2, 1, 0, 3), 8'hB, 32'h00AB_CDEF, 32'h1},
      '{32'h1, 32'h0, 32'hF, c(7, 2, 1, 2, 1, 0, 0), 8'h0, 32'h8, 32'h0},
      '{32'h1111_2222, 32'h8000, 32'h0, c(1, 1, 1, 2, 0, 0, 0), 8'h0, 32'h1111_8000, 32'h8},
      '{32'h5, 32'h0, 32'h0, c(19, 0, 1, 2, 0, 0, 0), 8'h0, 32'h5, 32'h0}};
    do_reset;
    rchk(dp_pkg::OFF_FLAGS, 32'h0, 32'hFFFF_FFFF);
    // Each row: load operands and flags, execute, read result and flags back
    foreach (rows[i]) begin
      wr(8'h44, rows[i].a);
      wr(8'h48, rows[i].b);
      wr(dp_pkg::OFF_IMM, rows[i].imm);
      wr(dp_pkg::OFF_FLAGS, {24'h00_0000, rows[i].fin});
      wr(dp_pkg::OFF_CMD, rows[i].cmd);
      rchk(8'h44, rows[i].exp, 32'hFFFF_FFFF);
      rchk(dp_pkg::OFF_FLAGS, rows[i].fexp, 32'hF);
    end
    rchk(dp_pkg::OFF_STATUS, 32'h1, 32'h1);
    cmp({31'h0000_0000, hresp}, 32'h0000_0000);
    wr(dp_pkg::OFF_STATUS, 32'h1);
    rchk(dp_pkg::OFF_STATUS, 32'h0, 32'h1);
    // Push then pop through the stack pointer, big-endian memory
    wr(8'h5C, 32'h10);
    wr(8'h4C, 32'hCAFE_BABE);
    wr(dp_pkg::OFF_CMD, c(6, 2, 0, 3, 0, 0, 0));
    rchk(8'h5C, 32'hC, 32'hFFFF_FFFF);
    rchk(8'h8C, 32'hCAFE_BABE, 32'hFFFF_FFFF);
    wr(dp_pkg::OFF_CMD, c(5, 1, 4, 0, 0, 0, 0));
    rchk(8'h50, 32'hCAFE, 32'hFFFF_FFFF);
    rchk(8'h5C, 32'hE, 32'hFFFF_FFFF);
    // Store and byte load with a negative 8-bit displacement
    wr(8'h54, 32'h14);
    wr(dp_pkg::OFF_IMM, 32'hFC);
    wr(dp_pkg::OFF_CMD, c(4, 2, 5, 3, 0, 0, 1));
    rchk(8'h90, 32'hCAFE_BABE, 32'hFFFF_FFFF);
    wr(dp_pkg::OFF_CMD, c(3, 0, 6, 5, 0, 0, 1));
    rchk(8'h58, 32'hCA, 32'hFFFF_FFFF);
    rchk(8'h30, 32'h0, 32'hFFFF_FFFF);
    // Reset in mid-run clears registers and flags
    do_reset;
    rchk(8'h4C, 32'h0, 32'hFFFF_FFFF);
    rchk(dp_pkg::OFF_FLAGS, 32'h0, 32'hFFFF_FFFF);
    end_of_test;
  end
endmodule // tb_top
